// >>> tb/ppe_core_model.sv
// core side model: one-cycle instruction and acknowledge strobes
// assumes calls start just after a rising pclk edge
`timescale 1ns/1ns
module ppe_core_model
    import ppe_pkg::*;
(
    input wire logic pclk,
    output ppe_core_t core_out
);
    initial core_out = '0;
    // dly lets the core answer late
    task automatic send(input ppe_core_t c, input int dly);
        repeat (dly) @(posedge pclk);
        core_out <= c;
        @(posedge pclk);
        core_out <= '0;
        @(posedge pclk);
    endtask
endmodule // ppe_core_model

// >>> tb/tb.sv
// bench for the port pin interrupt priority block
// assumes one-cycle apb answers and the core model beside it
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module tb
    import ppe_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_seen;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0] porta_pin;
    logic [3:0] portc_pin;
    ppe_core_t core_in;
    ppe_vec_t vec_out;
    int miscompares, compares;
    localparam logic [15:0] REGS [6] = '{16'h3F10, 16'h3F14, 16'h3F1C, 16'h3F20,
        16'h3F34, 16'h3F3C};
    localparam logic [31:0] FULL [6] = '{32'hFF, 32'hFF, 32'h0F, 32'h0F, 32'hFF, 32'h80};
    localparam logic [3:0] STRB [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    localparam logic [31:0] ENX [4] = '{32'h80, 32'h0, 32'h80, 32'h0};
    localparam logic [6:0] VX [3] = '{7'h71, 7'h68, 7'h50};
    ppe_port_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .porta_pin(porta_pin),
        .portc_pin(portc_pin), .core_in(core_in), .vec_out(vec_out), .irq(irq));
    ppe_core_model u_core (.pclk(pclk), .core_out(core_in));
    task automatic req(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rdat = prdata;
        err_seen = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic t_reset;
        `CHK("irq", 1'h0, irq)
        foreach (REGS[i]) begin
            req(1'h0, REGS[i], 32'h0);
            `CHK("reset value", 32'h0, rdat)
        end
        $display("test reset done");
    endtask
    task automatic t_regs;
        foreach (REGS[i]) begin
            req(1'h1, REGS[i], 32'hFFFFFFFF);
            req(1'h0, REGS[i], 32'h0);
            `CHK("register", FULL[i], rdat)
        end
        req(1'h1, 16'h3F3C, 32'h0);
        req(1'h0, 16'h3F3C, 32'h0);
        `CHK("enable write zero", 32'h0, rdat)
        req(1'h0, 16'h3F18, 32'h0);
        `CHK("unmapped error", 1'h1, err_seen)
        $display("test regs done");
    endtask
    task automatic t_ctl;
        foreach (STRB[i]) begin
            u_core.send(STRB[i], i);
            req(1'h0, 16'h3F3C, 32'h0);
            `CHK("enable strobe", ENX[i], rdat)
        end
        $display("test ctl done");
    endtask
    task automatic t_prio;
        req(1'h1, 16'h3F44, 32'hFFF);
        req(1'h1, 16'h3F40, 32'hFFF);
        req(1'h1, 16'h3F10, 32'h02);
        req(1'h1, 16'h3F14, 32'h03);
        req(1'h1, 16'h3F1C, 32'h01);
        req(1'h1, 16'h3F20, 32'h00);
        req(1'h1, 16'h3F34, 32'h0F);
        req(1'h1, 16'h3F3C, 32'h80);
        porta_pin <= 8'h0F;
        portc_pin <= 4'h1;
        repeat (6) @(posedge pclk);
        `CHK("irq", 1'h1, irq)
        for (int i = 0; i < 3; i++) begin
            `CHK("vector", VX[i], vec_out)
            u_core.send(4'h1, 2 * i);
            repeat (2) @(posedge pclk);
            `CHK("gated", 1'h0, vec_out.valid)
            u_core.send(i[0] ? 4'h2 : 4'h8, 0);
            repeat (3) @(posedge pclk);
        end
        `CHK("disabled pin", 1'h0, vec_out.valid)
        req(1'h0, 16'h3F40, 32'h0);
        `CHK("pending", 32'hC, rdat)
        porta_pin <= 8'h00;
        portc_pin <= 4'h0;
        repeat (6) @(posedge pclk);
        $display("test prio done");
    endtask
    task automatic t_edge;
        req(1'h1, 16'h3F34, 32'h20);
        req(1'h1, 16'h3F40, 32'hFFF);
        porta_pin <= 8'h30;
        repeat (2) @(posedge pclk);
        porta_pin <= 8'h10;
        repeat (5) @(posedge pclk);
        req(1'h0, 16'h3F40, 32'h0);
        `CHK("short pulse", 32'h20, rdat)
        porta_pin <= 8'h00;
        repeat (5) @(posedge pclk);
        req(1'h0, 16'h3F40, 32'h0);
        `CHK("falling edge", 32'h30, rdat)
        $display("test edge done");
    endtask
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        finish_test;
    end
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        porta_pin = 8'h0;
        portc_pin = 4'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_reset;
        t_regs;
        t_ctl;
        t_prio;
        t_edge;
        finish_test;
    end
endmodule // tb

// >>> verilog/ppe_consts.svh
// constants for the port pin interrupt priority block
// assumes an apb slave with 32-bit data, one register per word
`ifndef PPE_CONSTS_SVH
`define PPE_CONSTS_SVH
`define PPE_IDX_PA_HI 12'hFC4
`define PPE_IDX_PA_LO 12'hFC5
`define PPE_IDX_PC_HI 12'hFC7
`define PPE_IDX_PC_LO 12'hFC8
`define PPE_IDX_EDGE 12'hFCD
`define PPE_IDX_CTL 12'hFCF
`define PPE_IDX_PEND 12'hFD0
`define PPE_IDX_MASK 12'hFD1
`define PPE_IDX_VEC 12'hFD2
`define PPE_IE_BIT 7
`define PPE_PC_MASK 8'h0F
`define PPE_RST8 8'h00
`define PPE_NPIN 12
`endif

// >>> verilog/ppe_edge_det.sv
// pin synchroniser and edge detector for one request group
// assumes asynchronous pin inputs and the apb clock
`timescale 1ns/1ns
module ppe_edge_det #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] pin,
    input wire logic [W-1:0] rise_sel,
    output logic [W-1:0] edge_pulse
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // rise when selected, else fall; pulses over one clock survive sync
    always_comb begin
        edge_pulse = (rise_sel & s2_r & ~s3_r) | (~rise_sel & ~s2_r & s3_r);
    end
endmodule // ppe_edge_det

// >>> verilog/ppe_pkg.sv
// types for the port pin interrupt priority block
// assumes the constants header is included by users
package ppe_pkg;
    typedef enum logic [1:0] {
        PPE_OFF = 2'h0,
        PPE_LV1 = 2'h1,
        PPE_LV2 = 2'h2,
        PPE_LV3 = 2'h3
    } ppe_level_t;
    typedef struct packed {
        logic ei;
        logic di;
        logic interrupt_return_instr;
        logic ack;
    } ppe_core_t;
    typedef struct packed {
        logic valid;
        logic [1:0] level;
        logic [3:0] source;
    } ppe_vec_t;
endpackage

// >>> verilog/ppe_port_irq.sv
// port pin interrupt priority enables, edge select and master enable
// assumes an apb master on pclk and a core giving one-cycle instruction strobes
`timescale 1ns/1ns
`include "ppe_consts.svh"
module ppe_port_irq
    import ppe_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] porta_pin,
    input wire logic [3:0] portc_pin,
    input wire ppe_core_t core_in,
    output ppe_vec_t vec_out,
    output logic irq
);
    logic [7:0] pa_hi_r;
    logic [7:0] pa_lo_r;
    logic [7:0] pc_hi_r;
    logic [7:0] pc_lo_r;
    logic [7:0] edge_r;
    logic ie_r;
    logic [11:0] pend_r;
    logic [11:0] pend_nxt;
    logic [11:0] mask_r;
    logic [7:0] pa_edge;
    logic [3:0] pc_edge;
    logic [11:0] events;
    logic [11:0] en_hi;
    logic [11:0] en_lo;
    ppe_vec_t best;
    ppe_vec_t vec_r;
    logic irq_r;
    logic [31:0] rdata_r;
    logic wr_acc;
    logic rd_acc;
    logic [13:0] widx;
    logic mapped;
    logic [31:0] rmux;
    logic ready_r;
    logic slverr_r;

    function automatic ppe_level_t lvl(input logic hi, input logic lo);
        lvl = ppe_level_t'({hi, lo});
    endfunction

    function automatic logic hit(input logic [13:0] idx, input logic [11:0] reg_idx);
        hit = (idx == {2'h0, reg_idx});
    endfunction

    ppe_edge_det #(.W(8)) u_pa (
        .pclk(pclk),
        .presetn(presetn),
        .pin(porta_pin),
        .rise_sel(edge_r),
        .edge_pulse(pa_edge)
    );

    ppe_edge_det #(.W(4)) u_pc (
        .pclk(pclk),
        .presetn(presetn),
        .pin(portc_pin),
        .rise_sel(4'hF),
        .edge_pulse(pc_edge)
    );

    assign events = {pc_edge, pa_edge};
    assign en_hi = {pc_hi_r[3:0], pa_hi_r};
    assign en_lo = {pc_lo_r[3:0], pa_lo_r};
    assign widx = paddr[15:2];
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign mapped = hit(widx, `PPE_IDX_PA_HI) || hit(widx, `PPE_IDX_PA_LO)
        || hit(widx, `PPE_IDX_PC_HI) || hit(widx, `PPE_IDX_PC_LO)
        || hit(widx, `PPE_IDX_EDGE) || hit(widx, `PPE_IDX_CTL)
        || hit(widx, `PPE_IDX_PEND) || hit(widx, `PPE_IDX_MASK)
        || hit(widx, `PPE_IDX_VEC);

    // port a high enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_hi_r <= `PPE_RST8;
        end else if (wr_acc && hit(widx, `PPE_IDX_PA_HI)) begin
            pa_hi_r <= pwdata[7:0];
        end
    end

    // port a low enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_lo_r <= `PPE_RST8;
        end else if (wr_acc && hit(widx, `PPE_IDX_PA_LO)) begin
            pa_lo_r <= pwdata[7:0];
        end
    end

    // port c high enables, reserved bits forced to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_hi_r <= `PPE_RST8;
        end else if (wr_acc && hit(widx, `PPE_IDX_PC_HI)) begin
            pc_hi_r <= pwdata[7:0] & `PPE_PC_MASK;
        end
    end

    // port c low enables, reserved bits forced to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_lo_r <= `PPE_RST8;
        end else if (wr_acc && hit(widx, `PPE_IDX_PC_LO)) begin
            pc_lo_r <= pwdata[7:0] & `PPE_PC_MASK;
        end
    end

    // port a edge polarity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_r <= `PPE_RST8;
        end else if (wr_acc && hit(widx, `PPE_IDX_EDGE)) begin
            edge_r <= pwdata[7:0];
        end
    end

    // interrupt line mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= '0;
        end else if (wr_acc && hit(widx, `PPE_IDX_MASK)) begin
            mask_r <= pwdata[11:0];
        end
    end

    // ready comes from a flop; every access phase is one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= 1'b1;
        end
    end

    // error decided in setup, held through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slverr_r <= 1'b0;
        end else if (psel && !penable) begin
            slverr_r <= !mapped;
        end else if (!(psel && penable)) begin
            slverr_r <= 1'b0;
        end
    end

    // master enable; di and ack win over ei and return, and core strobes win over a control write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_r <= 1'b0;
        end else if (core_in.di || core_in.ack) begin
            ie_r <= 1'b0;
        end else if (core_in.ei || core_in.interrupt_return_instr) begin
            ie_r <= 1'b1;
        end else if (wr_acc && hit(widx, `PPE_IDX_CTL)) begin
            ie_r <= pwdata[`PPE_IE_BIT];
        end
    end

    // pending: set wins over write-one-clear and over acknowledge
    always_comb begin
        pend_nxt = pend_r;
        if (wr_acc && hit(widx, `PPE_IDX_PEND)) begin
            pend_nxt = pend_nxt & ~pwdata[11:0];
        end
        if (core_in.ack && vec_r.valid) begin
            pend_nxt[vec_r.source] = 1'b0;
        end
        pend_nxt = pend_nxt | events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= '0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // highest level wins, lowest index breaks ties
    always_comb begin
        best = '0;
        for (int i = `PPE_NPIN - 1; i >= 0; i--) begin
            if (pend_r[i] && lvl(en_hi[i], en_lo[i]) != PPE_OFF
                && lvl(en_hi[i], en_lo[i]) >= ppe_level_t'(best.level)) begin
                best.valid = 1'b1;
                best.level = lvl(en_hi[i], en_lo[i]);
                best.source = 4'(i);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_r <= '0;
        end else begin
            vec_r <= ie_r ? best : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(pend_r & mask_r);
        end
    end

    always_comb begin
        rmux = '0;
        if (hit(widx, `PPE_IDX_PA_HI)) rmux[7:0] = pa_hi_r;
        if (hit(widx, `PPE_IDX_PA_LO)) rmux[7:0] = pa_lo_r;
        if (hit(widx, `PPE_IDX_PC_HI)) rmux[7:0] = pc_hi_r;
        if (hit(widx, `PPE_IDX_PC_LO)) rmux[7:0] = pc_lo_r;
        if (hit(widx, `PPE_IDX_EDGE)) rmux[7:0] = edge_r;
        if (hit(widx, `PPE_IDX_CTL)) rmux[`PPE_IE_BIT] = ie_r;
        if (hit(widx, `PPE_IDX_PEND)) rmux[11:0] = pend_r;
        if (hit(widx, `PPE_IDX_MASK)) rmux[11:0] = mask_r;
        if (hit(widx, `PPE_IDX_VEC)) rmux[6:0] = vec_r;
    end

    // read data captured in setup, answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= '0;
        end else if (rd_acc) begin
            rdata_r <= rmux;
        end
    end

    assign prdata = rdata_r;
    assign pready = ready_r;
    assign pslverr = slverr_r;
    assign vec_out = vec_r;
    assign irq = irq_r;

    a_ie_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (core_in.di || core_in.ack) |=> !ie_r) else $error("master enable not cleared");
    a_ie_set: assert property (@(posedge pclk) disable iff (!presetn)
        (core_in.ei && !core_in.di && !core_in.ack) |=> ie_r)
        else $error("master enable not set");
    a_vec_gate: assert property (@(posedge pclk) disable iff (!presetn)
        vec_out.valid |-> $past(ie_r)) else $error("vector without master enable");
    a_pend_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (pend_r[0] && !core_in.ack && !wr_acc) |=> pend_r[0])
        else $error("pending bit lost");
    a_pend_set: assert property (@(posedge pclk) disable iff (!presetn)
        events[0] |=> pend_r[0]) else $error("event not latched");
    a_pc_upper: assert property (@(posedge pclk) disable iff (!presetn)
        (pc_hi_r[7:4] == 4'h0) && (pc_lo_r[7:4] == 4'h0))
        else $error("port c reserved bits set");
    a_vec_level: assert property (@(posedge pclk) disable iff (!presetn)
        (ie_r && best.valid) |=> (vec_out.level == $past(best.level)))
        else $error("vector level wrong");
    a_edge_fall: assert property (@(posedge pclk) disable iff (!presetn)
        (!edge_r[0] && $fell(u_pa.s2_r[0])) |-> pa_edge[0])
        else $error("falling edge missed");

    a_pa_hi_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit(widx, `PPE_IDX_PA_HI)) |=> (pa_hi_r == $past(pwdata[7:0])))
        else $error("port a high write lost");

    a_pa_lo_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit(widx, `PPE_IDX_PA_LO)) |=> (pa_lo_r == $past(pwdata[7:0])))
        else $error("port a low write lost");

    a_pc_hi_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit(widx, `PPE_IDX_PC_HI)) |=> (pc_hi_r[3:0] == $past(pwdata[3:0])))
        else $error("port c high write lost");

    a_pc_lo_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit(widx, `PPE_IDX_PC_LO)) |=> (pc_lo_r[3:0] == $past(pwdata[3:0])))
        else $error("port c low write lost");

    a_edge_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit(widx, `PPE_IDX_EDGE)) |=> (edge_r == $past(pwdata[7:0])))
        else $error("edge select write lost");

    a_ctl_resv: assert property (@(posedge pclk) disable iff (!presetn)
        hit(widx, `PPE_IDX_CTL) |-> (rmux[6:0] == 7'h00))
        else $error("control reserved bits not zero");

    a_vec_off: assert property (@(posedge pclk) disable iff (!presetn)
        !ie_r |=> !vec_out.valid)
        else $error("vector while disabled");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        (|(pend_r & mask_r)) |=> irq)
        else $error("irq not raised");

    a_bus_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable) |-> pready)
        else $error("access phase without ready");

    a_bus_err: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !mapped) |-> pslverr)
        else $error("unmapped access without error");
endmodule // ppe_port_irq
